//--- pkg/twb_pkg.sv
// Constants and types shared by the two-wire bus framing block.
package twb_pkg;

	// ----------------------------------------------------------------
	// Packet geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W    = 7;
	localparam int unsigned BYTE_W    = 8;
	localparam int unsigned CNT_W     = 4;
	localparam logic [3:0]  BYTE_BITS = 4'h8;
	localparam logic [3:0]  CNT_RST   = 4'h0;

	// ----------------------------------------------------------------
	// Address space
	// ----------------------------------------------------------------
	localparam logic [6:0] GCALL_ADDR = 7'h00;
	localparam logic [3:0] RSVD_TOP   = 4'hf;
	localparam logic       DIR_READ   = 1'b1;

	// ----------------------------------------------------------------
	// Reset values and open-drain driver level
	// ----------------------------------------------------------------
	localparam logic       LINE_IDLE = 1'b1;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic       PULL_LOW  = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned SYNC_STAGES   = 2;

	// ----------------------------------------------------------------
	// Slave framing states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE,
		S_ADDR,
		S_ADDR_ACK,
		S_RX,
		S_RX_ACK,
		S_TX_LOAD,
		S_TX,
		S_TX_ACK,
		S_IGNORE
	} twb_state_e;

endpackage : twb_pkg

//--- rtl/twb_cond.sv
// Clock edge and start/stop condition detector on synchronised lines.
`timescale 1ns/10ps
`default_nettype none

module twb_cond (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic scl_rise_o,
	output var  logic scl_fall_o,
	output var  logic start_o,
	output var  logic stop_o
);
	import twb_pkg::*;

	logic scl_r;
	logic sda_r;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			scl_r <= LINE_IDLE;
			sda_r <= LINE_IDLE;
		end else begin
			scl_r <= scl_i;
			sda_r <= sda_i;
		end
	end

	// An SDA change while SCL stays high is a condition, never data.
	always_comb begin
		scl_rise_o = scl_i & ~scl_r;
		scl_fall_o = ~scl_i & scl_r;
		start_o    = scl_i & scl_r & sda_r & ~sda_i;
		stop_o     = scl_i & scl_r & ~sda_r & sda_i;
	end

endmodule : twb_cond
`default_nettype wire

//--- rtl/twb_slave.sv
// Two-wire bus slave framing: conditions, address packet, data packets, acknowledge.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - SDA is only changed while SCL is low, outside start and stop.
// - SDA edges while SCL is high are detected as start or stop.
// - Bus is flagged busy from a start until the next stop.
// - A repeated start restarts address reception; bus stays busy.
// - Address packet: seven address bits, direction bit, acknowledge bit.
// - Direction one means read, zero means write.
// - Own address matched: SDA pulled low in the ninth clock.
// - Unmatched or unusable address: SDA left high, wait for stop or start.
// - Address bits arrive most significant bit first.
// - Address zero is general call, never an individual address.
// - General call write is acknowledged when enabled; data then received.
// - Own addresses 1111xxx are reserved and never matched.
// - Data packet: eight data bits then one acknowledge bit.
// - Master clocks the bus; the receiving party acknowledges.
// - Acknowledge is SDA low in the ninth clock; high means not-acknowledge.
// - A byte that cannot be taken is answered with not-acknowledge.
// - Data bytes go out most significant bit first.
// - Interface works only while the power gate input is zero.
// - Lines are only pulled low or released, never driven high.
// - Seven-bit address field, up to 119 usable own addresses.
// - SCL is held low while no transmit byte is ready.
module twb_slave (
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      two_wire_power_gate_i,
	input  wire logic [twb_pkg::ADDR_W-1:0] own_addr_i,
	input  wire logic                      gcall_en_i,
	input  wire logic                      rx_accept_i,
	input  wire logic [twb_pkg::BYTE_W-1:0] tx_data_i,
	input  wire logic                      tx_valid_i,
	input  wire logic                      scl_i,
	output var  logic                      scl_o,
	output var  logic                      scl_oe_o,
	input  wire logic                      sda_i,
	output var  logic                      sda_o,
	output var  logic                      sda_oe_o,
	output var  logic [twb_pkg::BYTE_W-1:0] rx_data_o,
	output var  logic                      rx_valid_o,
	output var  logic                      tx_ready_o,
	output var  logic                      start_o,
	output var  logic                      stop_o,
	output var  logic                      bus_busy_o,
	output var  logic                      addressed_o,
	output var  logic                      dir_read_o,
	output var  logic                      gcall_o,
	output var  logic                      tx_nack_o
);
	import twb_pkg::*;

	// ----------------------------------------------------------------
	// Line sampling
	// ----------------------------------------------------------------
	logic [1:0] lines_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;

	twb_sync #(.WIDTH(SYNC_STAGES)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.async_i ({scl_i, sda_i}),
		.sync_o  (lines_s)
	);

	assign scl_s = lines_s[1];
	assign sda_s = lines_s[0];

	twb_cond u_cond (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.scl_i      (scl_s),
		.sda_i      (sda_s),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (start_ev),
		.stop_o     (stop_ev)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	twb_state_e        state_r,     state_nxt;
	logic [CNT_W-1:0]  cnt_r,       cnt_nxt;
	logic [BYTE_W-1:0] shift_r,     shift_nxt;
	logic              ack_r,       ack_nxt;
	logic              sda_oe_r,    sda_oe_nxt;
	logic              scl_oe_r,    scl_oe_nxt;
	logic [BYTE_W-1:0] rx_data_r,   rx_data_nxt;
	logic              rx_valid_r,  rx_valid_nxt;
	logic              tx_ready_r,  tx_ready_nxt;
	logic              start_r,     start_nxt;
	logic              stop_r,      stop_nxt;
	logic              busy_r,      busy_nxt;
	logic              addressed_r, addressed_nxt;
	logic              read_r,      read_nxt;
	logic              gcall_r,     gcall_nxt;
	logic              nack_r,      nack_nxt;

	logic own_ok;
	logic addr_hit;
	logic gc_hit;
	logic byte_end;

	// ----------------------------------------------------------------
	// Address recognition
	// ----------------------------------------------------------------
	always_comb begin
		own_ok   = (own_addr_i != GCALL_ADDR) && (own_addr_i[6:3] != RSVD_TOP);
		addr_hit = own_ok && (shift_r[7:1] == own_addr_i);
		gc_hit   = gcall_en_i && (shift_r[7:1] == GCALL_ADDR) && (shift_r[0] != DIR_READ);
		byte_end = scl_fall && (cnt_r == BYTE_BITS);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt     = state_r;
		cnt_nxt       = cnt_r;
		shift_nxt     = shift_r;
		ack_nxt       = ack_r;
		sda_oe_nxt    = sda_oe_r;
		scl_oe_nxt    = 1'b0;
		rx_data_nxt   = rx_data_r;
		rx_valid_nxt  = 1'b0;
		tx_ready_nxt  = 1'b0;
		start_nxt     = 1'b0;
		stop_nxt      = 1'b0;
		busy_nxt      = busy_r;
		addressed_nxt = addressed_r;
		read_nxt      = read_r;
		gcall_nxt     = gcall_r;
		nack_nxt      = 1'b0;
		if (two_wire_power_gate_i) begin
			state_nxt     = S_IDLE;
			sda_oe_nxt    = 1'b0;
			busy_nxt      = 1'b0;
			addressed_nxt = 1'b0;
			cnt_nxt       = CNT_RST;
		end else if (start_ev) begin
			state_nxt     = S_ADDR;
			cnt_nxt       = CNT_RST;
			sda_oe_nxt    = 1'b0;
			start_nxt     = 1'b1;
			busy_nxt      = 1'b1;
			addressed_nxt = 1'b0;
			gcall_nxt     = 1'b0;
		end else if (stop_ev) begin
			state_nxt     = S_IDLE;
			sda_oe_nxt    = 1'b0;
			stop_nxt      = 1'b1;
			busy_nxt      = 1'b0;
			addressed_nxt = 1'b0;
		end else begin
			unique case (state_r)
				S_IDLE, S_IGNORE: begin
					sda_oe_nxt = 1'b0;
				end
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_s};
						cnt_nxt   = cnt_r + 4'h1;
					end else if (byte_end && state_r == S_ADDR) begin
						if (addr_hit || gc_hit) begin
							state_nxt     = S_ADDR_ACK;
							sda_oe_nxt    = 1'b1;
							addressed_nxt = 1'b1;
							read_nxt      = (shift_r[0] == DIR_READ);
							gcall_nxt     = gc_hit;
						end else begin
							state_nxt = S_IGNORE;
						end
					end else if (byte_end) begin
						state_nxt    = S_RX_ACK;
						rx_data_nxt  = shift_r;
						rx_valid_nxt = 1'b1;
						ack_nxt      = rx_accept_i;
						sda_oe_nxt   = rx_accept_i;
					end
				end
				S_ADDR_ACK: begin
					if (scl_fall) begin
						sda_oe_nxt = 1'b0;
						cnt_nxt    = CNT_RST;
						shift_nxt  = BYTE_RST;
						state_nxt  = read_r ? S_TX_LOAD : S_RX;
					end
				end
				S_RX_ACK: begin
					if (scl_fall) begin
						sda_oe_nxt = 1'b0;
						cnt_nxt    = CNT_RST;
						state_nxt  = ack_r ? S_RX : S_IGNORE;
					end
				end
				S_TX_LOAD: begin
					if (tx_valid_i) begin
						shift_nxt    = tx_data_i;
						sda_oe_nxt   = ~tx_data_i[7];
						tx_ready_nxt = 1'b1;
						cnt_nxt      = CNT_RST;
						state_nxt    = S_TX;
					end else begin
						scl_oe_nxt = 1'b1;
					end
				end
				S_TX: begin
					if (scl_rise) begin
						cnt_nxt = cnt_r + 4'h1;
					end else if (byte_end) begin
						sda_oe_nxt = 1'b0;
						state_nxt  = S_TX_ACK;
					end else if (scl_fall) begin
						shift_nxt  = {shift_r[6:0], 1'b0};
						sda_oe_nxt = ~shift_r[6];
					end
				end
				S_TX_ACK: begin
					if (scl_rise) begin
						ack_nxt = ~sda_s;
					end else if (scl_fall) begin
						if (ack_r) begin
							state_nxt = S_TX_LOAD;
						end else begin
							nack_nxt  = 1'b1;
							state_nxt = S_IGNORE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r     <= S_IDLE;
			cnt_r       <= CNT_RST;
			shift_r     <= BYTE_RST;
			ack_r       <= 1'b0;
			sda_oe_r    <= 1'b0;
			scl_oe_r    <= 1'b0;
			rx_data_r   <= BYTE_RST;
			rx_valid_r  <= 1'b0;
			tx_ready_r  <= 1'b0;
			start_r     <= 1'b0;
			stop_r      <= 1'b0;
			busy_r      <= 1'b0;
			addressed_r <= 1'b0;
			read_r      <= 1'b0;
			gcall_r     <= 1'b0;
			nack_r      <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			cnt_r       <= cnt_nxt;
			shift_r     <= shift_nxt;
			ack_r       <= ack_nxt;
			sda_oe_r    <= sda_oe_nxt;
			scl_oe_r    <= scl_oe_nxt;
			rx_data_r   <= rx_data_nxt;
			rx_valid_r  <= rx_valid_nxt;
			tx_ready_r  <= tx_ready_nxt;
			start_r     <= start_nxt;
			stop_r      <= stop_nxt;
			busy_r      <= busy_nxt;
			addressed_r <= addressed_nxt;
			read_r      <= read_nxt;
			gcall_r     <= gcall_nxt;
			nack_r      <= nack_nxt;
		end
	end

	// Open-drain drivers only ever pull low.
	logic scl_lvl_r;
	logic sda_lvl_r;

	always_ff @(posedge clk_i) begin
		scl_lvl_r <= PULL_LOW;
		sda_lvl_r <= PULL_LOW;
	end

	assign scl_o       = scl_lvl_r;
	assign sda_o       = sda_lvl_r;
	assign scl_oe_o    = scl_oe_r;
	assign sda_oe_o    = sda_oe_r;
	assign rx_data_o   = rx_data_r;
	assign rx_valid_o  = rx_valid_r;
	assign tx_ready_o  = tx_ready_r;
	assign start_o     = start_r;
	assign stop_o      = stop_r;
	assign bus_busy_o  = busy_r;
	assign addressed_o = addressed_r;
	assign dir_read_o  = read_r;
	assign gcall_o     = gcall_r;
	assign tx_nack_o   = nack_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sda_change_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$changed(sda_oe_r) |-> !$past(scl_s) || $past(start_ev) || $past(stop_ev)
			|| $past(two_wire_power_gate_i))
		else $error("SDA drive changed while SCL was high");

	busy_on_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(start_ev && !two_wire_power_gate_i) |=> busy_r && start_r && state_r == S_ADDR)
		else $error("Start did not mark the bus busy");

	busy_off_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(stop_ev && !start_ev) |=> !busy_r && !sda_oe_r)
		else $error("Stop did not free the bus");

	addr_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == S_ADDR && byte_end && addr_hit && !start_ev && !stop_ev
			&& !two_wire_power_gate_i) |=> sda_oe_r && addressed_o
			&& dir_read_o == $past(shift_r[0]))
		else $error("Own address was not acknowledged");

	gcall_read_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == S_ADDR && byte_end && shift_r == 8'h01) |=> !sda_oe_r)
		else $error("General call read was acknowledged");

	rsvd_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == S_ADDR && byte_end && shift_r[7:4] == RSVD_TOP && !start_ev && !stop_ev
			&& !two_wire_power_gate_i) |=> !addressed_r && !sda_oe_r)
		else $error("Reserved address was acknowledged");

	rx_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == S_RX && byte_end && !start_ev && !stop_ev && !two_wire_power_gate_i)
			|=> sda_oe_r == $past(rx_accept_i) && rx_valid_r
			&& rx_data_r == $past(shift_r))
		else $error("Received byte acknowledge mismatch");

	tx_msb_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == S_TX_LOAD && tx_valid_i && !start_ev && !stop_ev
			&& !two_wire_power_gate_i) |=> sda_oe_r == !$past(tx_data_i[7]) && tx_ready_r)
		else $error("Transmit byte did not start with its MSB");

	scl_stretch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == S_TX_LOAD && !tx_valid_i && !start_ev && !stop_ev
			&& !two_wire_power_gate_i) |=> scl_oe_r)
		else $error("SCL not held while waiting for data");

	power_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		two_wire_power_gate_i [*2] |-> !sda_oe_r && !scl_oe_r && !busy_r)
		else $error("Interface active while gated off");

endmodule : twb_slave
`default_nettype wire

//--- rtl/twb_sync.sv
// Two-flop synchroniser for the bus lines.
`timescale 1ns/10ps
`default_nettype none

module twb_sync #(
	parameter int unsigned WIDTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output var  logic [WIDTH-1:0] sync_o
);
	import twb_pkg::*;

	logic [WIDTH-1:0] stg1_r;
	logic [WIDTH-1:0] stg2_r;

	// Both stages idle high so a reset never fakes a bus edge.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stg1_r <= {WIDTH{LINE_IDLE}};
			stg2_r <= {WIDTH{LINE_IDLE}};
		end else begin
			stg1_r <= async_i;
			stg2_r <= stg1_r;
		end
	end

	assign sync_o = stg2_r;

endmodule : twb_sync
`default_nettype wire

//--- testbench/test_twb_slave.sv
// Self-checking bench of the two-wire bus slave framing block.
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s expected %0h seen %0h", n, e, g); end end

module test_twb_slave;
	import twb_pkg::*;

	logic       clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	logic       two_wire_power_gate_i = 1'b0;
	logic [6:0] own_addr_i = 7'h5a;
	logic       gcall_en_i = 1'b0;
	logic       rx_accept_i = 1'b1;
	logic [7:0] tx_data_i = 8'h00;
	logic       tx_valid_i = 1'b0;
	logic       scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl_oe, m_sda_oe;
	logic [7:0] rx_data_o;
	logic       rx_valid_o, tx_ready_o, start_o, stop_o, bus_busy_o;
	logic       addressed_o, dir_read_o, gcall_o, tx_nack_o;
	logic       scl_line, sda_line, scl_prev, oe_prev;
	logic       glitch = 1'b0;
	int         failures = 0;
	int         checks = 0;
	int         starts = 0;
	int         rx_cnt = 0;
	int         tx_cnt = 0;
	int         nack_cnt = 0;
	int         stops = 0;

	always #2.5 clk_i = ~clk_i;

	assign scl_line = ~(m_scl_oe | scl_oe_o);
	assign sda_line = ~(m_sda_oe | sda_oe_o);

	twb_slave uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.two_wire_power_gate_i(two_wire_power_gate_i), .own_addr_i(own_addr_i),
		.gcall_en_i(gcall_en_i), .rx_accept_i(rx_accept_i), .tx_data_i(tx_data_i),
		.tx_valid_i(tx_valid_i), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rx_data_o(rx_data_o),
		.rx_valid_o(rx_valid_o), .tx_ready_o(tx_ready_o), .start_o(start_o),
		.stop_o(stop_o), .bus_busy_o(bus_busy_o), .addressed_o(addressed_o),
		.dir_read_o(dir_read_o), .gcall_o(gcall_o), .tx_nack_o(tx_nack_o));

	twb_master_model mdl (.clk_i(clk_i), .scl_i(scl_line), .sda_i(sda_line),
		.scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));

	// ----------------------------------------------------------------
	// Pulse counters and line watch
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (start_o === 1'b1) starts++;
		if (rx_valid_o === 1'b1) rx_cnt++;
		if (tx_ready_o === 1'b1) tx_cnt++;
		if (tx_nack_o === 1'b1) nack_cnt++;
		if (stop_o === 1'b1) stops++;
		if (tx_ready_o === 1'b1) tx_valid_i <= 1'b0;
		if (rst_n_i && scl_line && scl_prev && sda_oe_o !== oe_prev) glitch <= 1'b1;
		scl_prev <= scl_line;
		oe_prev <= sda_oe_o;
	end

	task automatic t_reset();
		`CHK("bus_busy", 1'b0, bus_busy_o)
		`CHK("sda_oe", 1'b0, sda_oe_o)
		`CHK("scl_oe", 1'b0, scl_oe_o)
		`CHK("sda_o", 1'b0, sda_o)
		`CHK("scl_o", 1'b0, scl_o)
		$display("test reset done");
	endtask : t_reset

	task automatic t_write();
		logic [7:0] q;
		logic       r;
		mdl.send_start();
		`CHK("bus_busy", 1'b1, bus_busy_o)
		mdl.xfer({7'h5a, 1'b0}, 1'b1, q, r);
		`CHK("addr ack", 1'b0, r)
		`CHK("addressed", 1'b1, addressed_o)
		`CHK("dir_read", 1'b0, dir_read_o)
		mdl.xfer(8'ha5, 1'b1, q, r);
		`CHK("data ack", 1'b0, r)
		`CHK("rx_data", 8'ha5, rx_data_o)
		rx_accept_i <= 1'b0;
		mdl.xfer(8'h3c, 1'b1, q, r);
		`CHK("data nack", 1'b1, r)
		`CHK("rx_data", 8'h3c, rx_data_o)
		mdl.send_stop();
		`CHK("bus_busy", 1'b0, bus_busy_o)
		`CHK("rx count", 2, rx_cnt)
		`CHK("stop count", 1, stops)
		$display("test write done");
	endtask : t_write

	task automatic t_read();
		logic [7:0] q;
		logic       r;
		mdl.send_start();
		mdl.xfer({7'h5a, 1'b1}, 1'b1, q, r);
		`CHK("addr ack", 1'b0, r)
		`CHK("dir_read", 1'b1, dir_read_o)
		fork
			mdl.xfer(8'hff, 1'b0, q, r);
			begin
				repeat (40) @(posedge clk_i);
				`CHK("scl hold", 1'b1, scl_oe_o)
				tx_data_i <= 8'hc3;
				tx_valid_i <= 1'b1;
			end
		join
		`CHK("tx byte", 8'hc3, q)
		`CHK("tx_ready count", 1, tx_cnt)
		tx_data_i <= 8'h81;
		tx_valid_i <= 1'b1;
		mdl.xfer(8'hff, 1'b1, q, r);
		`CHK("tx byte", 8'h81, q)
		mdl.send_stop();
		`CHK("tx_nack count", 1, nack_cnt)
		`CHK("tx_ready count", 2, tx_cnt)
		$display("test read done");
	endtask : t_read

	task automatic t_refuse();
		logic [7:0] q;
		logic       r;
		int         s0;
		logic [6:0] own  [4] = '{7'h11, 7'h7b, 7'h11, 7'h00};
		logic [7:0] sent [4] = '{8'h44, 8'hf6, 8'h01, 8'h00};
		logic       gen  [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
		s0 = starts;
		rx_accept_i <= 1'b1;
		mdl.send_start();
		for (int i = 0; i < 4; i++) begin
			own_addr_i <= own[i];
			gcall_en_i <= gen[i];
			mdl.xfer(sent[i], 1'b1, q, r);
			`CHK("refused ack", 1'b1, r)
			`CHK("addressed", 1'b0, addressed_o)
			mdl.send_start();
			`CHK("busy on restart", 1'b1, bus_busy_o)
		end
		`CHK("start count", s0 + 5, starts)
		gcall_en_i <= 1'b1;
		mdl.xfer(8'h00, 1'b1, q, r);
		`CHK("gcall ack", 1'b0, r)
		`CHK("gcall", 1'b1, gcall_o)
		mdl.xfer(8'h96, 1'b1, q, r);
		`CHK("gcall data", 8'h96, rx_data_o)
		mdl.send_stop();
		$display("test refuse done");
	endtask : t_refuse

	task automatic t_power();
		logic [7:0] q;
		logic       r;
		int         s0;
		s0 = starts;
		two_wire_power_gate_i <= 1'b1;
		own_addr_i <= 7'h5a;
		mdl.send_start();
		mdl.xfer({7'h5a, 1'b0}, 1'b1, q, r);
		`CHK("gated ack", 1'b1, r)
		`CHK("gated busy", 1'b0, bus_busy_o)
		`CHK("gated start", s0, starts)
		mdl.send_stop();
		two_wire_power_gate_i <= 1'b0;
		mdl.send_start();
		mdl.xfer({7'h5a, 1'b0}, 1'b1, q, r);
		`CHK("ungated ack", 1'b0, r)
		mdl.send_stop();
		`CHK("sda steady on high scl", 1'b0, glitch)
		$display("test power done");
	endtask : t_power

	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_reset();
		t_write();
		t_read();
		t_refuse();
		t_power();
		complete_run();
	end

	initial begin
		repeat (60000) @(posedge clk_i);
		failures++;
		$display("unexpected watchdog expected done seen timeout");
		complete_run();
	end
endmodule : test_twb_slave

`default_nettype wire

//--- testbench/twb_master_model.sv
// Bus master model that clocks frames onto the two-wire bus.
`timescale 1ns/10ps
`default_nettype none

module twb_master_model (
	input  wire logic clk_i,
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var  logic scl_oe_o,
	output var  logic sda_oe_o
);
	localparam int QUARTER = 4;

	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_clk

	// ----------------------------------------------------------------
	// Bit and condition timing
	// ----------------------------------------------------------------
	// Data changes mid low phase; the high phase is timed from the real line level.
	task automatic bit_cycle(input logic b, output logic r);
		int guard;
		wait_clk(QUARTER);
		sda_oe_o <= ~b;
		wait_clk(QUARTER);
		scl_oe_o <= 1'b0;
		guard = 0;
		while (scl_i !== 1'b1 && guard < 4000) begin
			@(posedge clk_i);
			guard++;
		end
		wait_clk(QUARTER);
		r = sda_i;
		wait_clk(QUARTER);
		scl_oe_o <= 1'b1;
	endtask : bit_cycle

	task automatic send_start();
		wait_clk(QUARTER);
		sda_oe_o <= 1'b0;
		wait_clk(2 * QUARTER);
		scl_oe_o <= 1'b0;
		wait_clk(2 * QUARTER);
		sda_oe_o <= 1'b1;
		wait_clk(2 * QUARTER);
		scl_oe_o <= 1'b1;
	endtask : send_start

	// Every frame sent carries an address packet before its stop.
	task automatic send_stop();
		wait_clk(QUARTER);
		sda_oe_o <= 1'b1;
		wait_clk(2 * QUARTER);
		scl_oe_o <= 1'b0;
		wait_clk(2 * QUARTER);
		sda_oe_o <= 1'b0;
		wait_clk(4 * QUARTER);
	endtask : send_stop

	// Eight bits of d go out, q collects the line, the ninth bit drives last.
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic r9);
		for (int i = 7; i >= 0; i--) bit_cycle(d[i], q[i]);
		bit_cycle(last, r9);
	endtask : xfer
endmodule : twb_master_model

`default_nettype wire
